//--- design/boot_strap_vector_upper_decode.sv
// Contract
// - bit 7 selects 8 or 16 bit boot
// - bit8 only sets reset mode reserved flag; reset line driven 4096 cycles after every cold release
// - bits 11:9 decode pci mode
// - modes 1,2 are satellite variants
// - modes 4,5 are internal-arbiter host
// - pci enable set only for modes 1,2
// - bit 12 disables watchdog after cold reset
// - sample during cold reset, then drive bus
// - captured vector readable by software
`timescale 1ns/1ps
`default_nettype none
module boot_strap_vector_upper_decode
    import boot_vec_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_power_on_reset_input_n,
    input wire logic [boot_vec_pkg::VEC_W-1:0] i_memory_data_strap_bus,
    input wire logic i_system_reset_line,
    output logic o_system_reset_line,
    output logic o_system_reset_line_oe,
    output logic o_memory_data_strap_bus_oe,
    output logic [boot_vec_pkg::VEC_W-1:0] o_boot_vector_readback,
    output logic o_boot_width_16,
    output logic o_reset_mode_reserved,
    output logic [2:0] o_pci_mode,
    output logic o_pci_mode_reserved,
    output logic o_pci_satellite,
    output logic o_pci_target_not_ready,
    output logic o_cpu_suspend,
    output logic o_pci_host,
    output logic o_pci_internal_arbiter,
    output logic o_pci_round_robin,
    output logic o_pci_control_register_en,
    output logic o_watchdog_enable,
    output logic o_strap_reserved_error,
    output logic o_warm_reset
);
    import boot_vec_pkg::*;

    typedef enum logic [1:0] {ST_COLD, ST_DRIVE, ST_RUN} phase_e;

    typedef struct packed {
        phase_e phase;
        logic [VEC_W-1:0] vec;
        logic [RST_CNT_W-1:0] cnt;
        logic rst_oe;
        logic bus_oe;
        logic pci_en;
        logic wdog_en;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic cold_n_s;
    logic [VEC_W-1:0] strap_s;
    logic rstl_s;
    logic [2:0] mode;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    boot_sync2 #(.W(VEC_W + 2)) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_power_on_reset_input_n, i_system_reset_line, i_memory_data_strap_bus}),
        .o_sync({cold_n_s, rstl_s, strap_s})
    );

    assign mode = s_q.vec[PCI_MODE_LSB +: PCI_MODE_W];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        s_d = s_q;
        case (s_q.phase)
            ST_COLD:
            begin
                s_d.bus_oe = 1'b0;
                s_d.rst_oe = 1'b1;
                s_d.cnt = '0;
                if (!cold_n_s)
                begin
                    s_d.vec = strap_s;
                end
                else
                begin
                    s_d.phase = ST_DRIVE;
                    s_d.bus_oe = 1'b1;
                    s_d.pci_en = (mode == PCI_SAT_NOT_READY) || (mode == PCI_SAT_SUSPEND);
                    s_d.wdog_en = !s_q.vec[WDOG_DIS_BIT];
                end
            end
            ST_DRIVE:
            begin
                s_d.cnt = s_q.cnt + RST_CNT_W'(1);
                if (s_q.cnt == RST_CNT_W'(RST_DRIVE_CYCLES - 1))
                begin
                    s_d.phase = ST_RUN;
                    s_d.rst_oe = 1'b0;
                end
            end
            ST_RUN:
            begin
                s_d.rst_oe = 1'b0;
            end
            default:
            begin
                s_d.phase = ST_COLD;
            end
        endcase
        if (!cold_n_s)
        begin
            s_d.phase = ST_COLD;
            s_d.bus_oe = 1'b0;
            s_d.rst_oe = 1'b1;
            if (s_q.phase == ST_COLD)
            begin
                s_d.vec = strap_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; vector untouched except by i_sys_rst (VEC_RESET) and cold sampling
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            s_q.phase <= ST_COLD;
            s_q.vec <= VEC_RESET;
            s_q.cnt <= '0;
            s_q.rst_oe <= 1'b1;
            s_q.bus_oe <= 1'b0;
            s_q.pci_en <= 1'b0;
            s_q.wdog_en <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded outputs
    assign o_system_reset_line = 1'b0;
    assign o_system_reset_line_oe = s_q.rst_oe;
    assign o_memory_data_strap_bus_oe = s_q.bus_oe;
    assign o_boot_vector_readback = s_q.vec;
    assign o_boot_width_16 = s_q.vec[BOOT_WIDTH_BIT];
    assign o_reset_mode_reserved = s_q.vec[RESET_MODE_BIT];
    assign o_pci_mode = mode;
    assign o_pci_mode_reserved = mode >= PCI_RSVD_MIN;
    assign o_pci_satellite = (mode == PCI_SAT_NOT_READY) || (mode == PCI_SAT_SUSPEND);
    assign o_pci_target_not_ready = mode == PCI_SAT_NOT_READY;
    assign o_cpu_suspend = mode == PCI_SAT_SUSPEND;
    assign o_pci_host = (mode == PCI_HOST_EXT_ARB) || (mode == PCI_HOST_FIXED) || (mode == PCI_HOST_RR);
    assign o_pci_internal_arbiter = (mode == PCI_HOST_FIXED) || (mode == PCI_HOST_RR);
    assign o_pci_round_robin = mode == PCI_HOST_RR;
    assign o_pci_control_register_en = s_q.pci_en;
    assign o_watchdog_enable = s_q.wdog_en;
    assign o_strap_reserved_error = |s_q.vec[RSVD_LSB +: RSVD_W];
    assign o_warm_reset = (s_q.phase == ST_RUN) && !rstl_s;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_drive_len;
        @(posedge i_clk) disable iff (i_sys_rst)
        $rose(s_q.phase == ST_DRIVE) |-> s_q.rst_oe [*8];
    endproperty
    a_drive_len: assert property (p_drive_len) else $error("reset line released early");

    property p_pci_en;
        @(posedge i_clk) disable iff (i_sys_rst)
        $rose(s_q.phase == ST_DRIVE) |-> s_q.pci_en == ((mode == 3'h1) || (mode == 3'h2));
    endproperty
    a_pci_en: assert property (p_pci_en) else $error("pci enable wrong for mode");

    property p_wdog;
        @(posedge i_clk) disable iff (i_sys_rst)
        $rose(s_q.phase == ST_DRIVE) |-> s_q.wdog_en == !s_q.vec[12];
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog enable wrong");

    property p_hold_vec;
        @(posedge i_clk) disable iff (i_sys_rst)
        (s_q.phase != ST_COLD) && cold_n_s |=> $stable(s_q.vec);
    endproperty
    a_hold_vec: assert property (p_hold_vec) else $error("vector changed outside cold reset");

    property p_bus_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        !cold_n_s |=> !s_q.bus_oe;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus driven during sampling");

    property p_sample;
        @(posedge i_clk) disable iff (i_sys_rst)
        !cold_n_s && (s_q.phase == ST_COLD) |=> s_q.vec == $past(strap_s);
    endproperty
    a_sample: assert property (p_sample) else $error("vector not sampled");

    property p_width;
        @(posedge i_clk) disable iff (i_sys_rst)
        !cold_n_s && (s_q.phase == ST_COLD) |=> o_boot_width_16 == $past(strap_s[BOOT_WIDTH_BIT]);
    endproperty
    a_width: assert property (p_width) else $error("boot width mismatch");

    property p_arb;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_pci_internal_arbiter |-> o_pci_host && !o_pci_satellite && (o_pci_mode inside {3'h4, 3'h5});
    endproperty
    a_arb: assert property (p_arb) else $error("arbiter decode wrong");

    // cold pin seen high while sampling: the release step
    sequence s_cold_release;
        (s_q.phase == ST_COLD) && cold_n_s;
    endsequence

    property p_release;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_cold_release |=> (s_q.phase == ST_DRIVE) && s_q.bus_oe && s_q.rst_oe && (s_q.cnt == '0);
    endproperty
    a_release: assert property (p_release) else $error("cold release did not start reset drive");

    property p_drive_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        (s_q.phase == ST_DRIVE) && cold_n_s && (s_q.cnt != RST_CNT_W'(RST_DRIVE_CYCLES - 1)) |=> s_q.rst_oe;
    endproperty
    a_drive_hold: assert property (p_drive_hold) else $error("reset line dropped inside drive window");

    property p_drive_end;
        @(posedge i_clk) disable iff (i_sys_rst)
        $fell(s_q.rst_oe) |-> $past(s_q.cnt) == RST_CNT_W'(RST_DRIVE_CYCLES - 1);
    endproperty
    a_drive_end: assert property (p_drive_end) else $error("reset line released before full count");

    property p_flags_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        (s_q.phase == ST_RUN) && cold_n_s |=> $stable(s_q.pci_en) && $stable(s_q.wdog_en);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("boot flags changed after release");
endmodule : boot_strap_vector_upper_decode
`default_nettype wire

//--- design/boot_vec_pkg.sv
package boot_vec_pkg;
    // vector width and field positions
    localparam int VEC_W = 16;
    localparam int BOOT_WIDTH_BIT = 7;
    localparam int RESET_MODE_BIT = 8;
    localparam int PCI_MODE_LSB = 9;
    localparam int PCI_MODE_W = 3;
    localparam int WDOG_DIS_BIT = 12;
    localparam int RSVD_LSB = 13;
    localparam int RSVD_W = 3;
    // pci mode codes
    localparam logic [2:0] PCI_DISABLED = 3'h0;
    localparam logic [2:0] PCI_SAT_NOT_READY = 3'h1;
    localparam logic [2:0] PCI_SAT_SUSPEND = 3'h2;
    localparam logic [2:0] PCI_HOST_EXT_ARB = 3'h3;
    localparam logic [2:0] PCI_HOST_FIXED = 3'h4;
    localparam logic [2:0] PCI_HOST_RR = 3'h5;
    localparam logic [2:0] PCI_RSVD_MIN = 3'h6;
    // reset values
    localparam logic [15:0] VEC_RESET = 16'h0000;
    // reset line drive time
    localparam int CLK_MHZ = 40;
    localparam int RST_DRIVE_CYCLES_DOC = 4096;
    localparam int RST_DRIVE_CYCLES = RST_DRIVE_CYCLES_DOC;
    localparam int RST_CNT_W = 13;
    // synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage : boot_vec_pkg

//--- design/boot_sync2.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser, one per bit
module boot_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    ////////////////////////////////////////////////////////////////////////
    // meta stage only feeds the second stage
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : boot_sync2
`default_nettype wire

//--- dv/strap_model.sv
`timescale 1ns/1ps
`default_nettype none
// board straps on the memory data bus
module strap_model (
    input wire logic i_clk,
    input wire logic i_bus_oe,
    input wire logic [15:0] i_strap,
    output logic [15:0] o_bus
);
    // straps while released, toggling junk once the device owns the bus
    always_ff @(posedge i_clk)
    begin
        if (i_bus_oe)
            o_bus <= ~o_bus;
        else
            o_bus <= i_strap;
    end
endmodule : strap_model
`default_nettype wire

//--- dv/tb_boot_strap_vector_upper_decode.sv
`timescale 1ns/1ps
`default_nettype none
module tb_boot_strap_vector_upper_decode;
    import boot_vec_pkg::*;
    logic clk, rst, cold_n, warm, line, line_o, line_oe, bus_oe;
    logic w16, rmr, pmr, sat, tnr, sus, host, iarb, rr, pen, wen, serr, warm_o;
    logic [2:0] pm;
    logic [15:0] strap, bus, rb, lfsr, s;
    logic [15:0] exp_q[$];
    int err_total, check_count, done, cyc;
    ////////////////////////////////////////////////////////////
    strap_model u_straps (.i_clk(clk), .i_bus_oe(bus_oe), .i_strap(strap), .o_bus(bus));
    // reset line: pull-up while released, device level while driven, warm source pulls low
    assign line = (line_oe ? line_o : 1'b1) && !warm;
    boot_strap_vector_upper_decode u_dut (
        .i_clk(clk), .i_sys_rst(rst), .i_power_on_reset_input_n(cold_n),
        .i_memory_data_strap_bus(bus), .i_system_reset_line(line),
        .o_system_reset_line(line_o), .o_system_reset_line_oe(line_oe),
        .o_memory_data_strap_bus_oe(bus_oe), .o_boot_vector_readback(rb),
        .o_boot_width_16(w16), .o_reset_mode_reserved(rmr), .o_pci_mode(pm),
        .o_pci_mode_reserved(pmr), .o_pci_satellite(sat), .o_pci_target_not_ready(tnr),
        .o_cpu_suspend(sus), .o_pci_host(host), .o_pci_internal_arbiter(iarb),
        .o_pci_round_robin(rr), .o_pci_control_register_en(pen),
        .o_watchdog_enable(wen), .o_strap_reserved_error(serr), .o_warm_reset(warm_o));
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : nxt
    // one compare task per kind of result
    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk_word
    task automatic chk_flag(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask : chk_flag
    task automatic chk_len(input string n, input int lo, input int hi, input int g);
        check_count++;
        if (g < lo || g > hi)
        begin
            err_total++;
            $display("BAD %s exp %0d to %0d got %0d", n, lo, hi, g);
        end
    endtask : chk_len
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////
    // clock and hang guard
    initial
    begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            err_total++;
            results();
        end
    end
    ////////////////////////////////////////////////////////////
    // watcher: decode and reset drive checked at each bus takeover
    initial
    begin
        logic [15:0] v;
        logic [15:0] e;
        logic [15:0] g;
        logic [2:0] m;
        int n;
        forever
        begin
            @(posedge bus_oe);
            @(negedge clk);
            v = exp_q.pop_front();
            m = v[11:9];
            // expected decode straight from the strap fields
            e = {1'b0, v[7], v[8], m, m >= 3'h6, m == 3'h1 || m == 3'h2, m == 3'h1, m == 3'h2,
                m >= 3'h3 && m <= 3'h5, m == 3'h4 || m == 3'h5, m == 3'h5, m == 3'h1 || m == 3'h2,
                !v[12], |v[15:13]};
            g = {1'b0, w16, rmr, pm, pmr, sat, tnr, sus, host, iarb, rr, pen, wen, serr};
            chk_word("rb", v, rb);
            chk_word("dec", e, g);
            chk_flag("line", 1'b0, line);
            chk_flag("warm_drv", 1'b0, warm_o);
            n = 0;
            while (line_oe && n < 5000)
            begin
                @(negedge clk);
                n++;
            end
            chk_len("drv", RST_DRIVE_CYCLES, RST_DRIVE_CYCLES + 2, n);
            chk_flag("line_rel", 1'b1, line);
            done++;
        end
    end
    ////////////////////////////////////////////////////////////
    // driver: every pci mode, then a reserved strap and a warm reset
    initial
    begin
        rst <= 1;
        cold_n <= 0;
        warm <= 0;
        strap <= 16'h0;
        lfsr = 16'h5;
        repeat (20) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 9; i++)
        begin
            lfsr = nxt(lfsr);
            s = {(i == 8) ? 3'h5 : 3'h0, lfsr[0], i[2:0], i == 8, lfsr[8:1]};
            cold_n <= 0;
            strap <= s;
            exp_q.push_back(s);
            repeat (10) @(posedge clk);
            cold_n <= 1;
            wait (done == i + 1);
            @(posedge clk);
        end
        strap <= ~s;
        warm <= 1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk_flag("warm", 1'b1, warm_o);
        chk_word("keep", s, rb);
        @(posedge clk);
        warm <= 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_flag("warm_off", 1'b0, warm_o);
        chk_word("keep_after", s, rb);
        results();
    end
endmodule : tb_boot_strap_vector_upper_decode
`default_nettype wire
